/* core/rpmc_pkg.sv */
// Package: register map, field layout and decode types for the amplifier and modem configuration
package rpmc_pkg;
	localparam int ADDR_W = 12;
	// Register indices; byte address is four times the index
	localparam logic [9:0] IDX_PA_CFG = 10'h114;
	localparam logic [9:0] IDX_MODEM_CFG = 10'h115;
	localparam logic [9:0] IDX_RATE_CFG = 10'h120;
	localparam logic [9:0] IDX_AMP_CTRL = 10'h121;
	localparam logic [9:0] IDX_AMP_STAT = 10'h122;
	localparam logic [9:0] IDX_FINE_PWR = 10'h307;
	// Field positions
	localparam int STAGE_BIT = 7;
	localparam int COARSE_LSB = 3;
	localparam int RAMP_LSB = 0;
	localparam int IF_FILTER_WIDTH_LSB = 6;
	localparam int MOD_LSB = 3;
	localparam int DEMOD_LSB = 0;
	// Reset values
	localparam logic [7:0] PA_CFG_RST = 8'h07;
	localparam logic [7:0] MODEM_CFG_RST = 8'h00;
	localparam logic [5:0] FINE_PWR_RST = 6'h03;
	localparam logic [11:0] RATE_CFG_RST = 12'h0FF;
	// Coarse to fine mapping
	localparam logic [5:0] FINE_OFFSET = 6'h03;
	// Ramp: codes per bit is 2 to the power (9 - code)
	localparam logic [3:0] RAMP_SHIFT_BASE = 4'h9;
	localparam logic [2:0] RAMP_RESERVED = 3'h0;
	// IF bandwidth table in kHz
	localparam logic [1:0] IF_FILTER_WIDTH_300K = 2'h3;
	localparam logic [8:0] BW_KHZ_0 = 9'h064;
	localparam logic [8:0] BW_KHZ_1 = 9'h096;
	localparam logic [8:0] BW_KHZ_2 = 9'h0C8;
	localparam logic [8:0] BW_KHZ_3 = 9'h12C;
	// Modulation and demodulation codes
	localparam logic [2:0] MOD_FSK = 3'h0;
	localparam logic [2:0] MOD_GFSK = 3'h1;
	localparam logic [2:0] MOD_CARRIER = 3'h3;
	localparam logic [2:0] DEMOD_COMMON = 3'h0;

	typedef struct packed {
		logic [8:0] if_bw_khz;
		logic if_freq_300k;
		logic mod_fsk;
		logic mod_gfsk;
		logic mod_carrier;
		logic mod_reserved;
		logic demod_common;
		logic demod_reserved;
	} rpmc_modem_t;

	typedef struct packed {
		logic single_en;
		logic diff_en;
		logic [5:0] level;
		logic ramping;
	} rpmc_amp_t;
endpackage

/* core/rpmc_top.sv */
// Amplifier ramp and modem configuration registers behind an APB slave
`timescale 1ns/1ps
module rpmc_top #(
	parameter int RATE_W = 12
) (
	input wire logic i_mclk,
	input wire logic i_srst,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [rpmc_pkg::ADDR_W-1:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	input wire logic [3:0] i_pstrb,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	output rpmc_pkg::rpmc_amp_t o_amp,
	output rpmc_pkg::rpmc_modem_t o_modem
);
	// The data-rate register and step counter are sized for twelve bits only
	if (RATE_W != 12) begin : g_bad_rate
		$error("rpmc_top: RATE_W must be 12");
	end

	logic [7:0] pa_cfg_r;
	logic [7:0] modem_cfg_r;
	logic [5:0] fine_r;
	logic [11:0] rate_r;
	logic amp_en_r;
	logic [5:0] level_r;
	logic [5:0] level_nxt;
	logic [11:0] step_cnt_r;
	logic [31:0] prdata_r;
	rpmc_pkg::rpmc_amp_t amp_r;
	rpmc_pkg::rpmc_modem_t modem_r;
	rpmc_pkg::rpmc_modem_t modem_nxt;

	// Bus decode
	wire [9:0] idx_w = i_paddr[rpmc_pkg::ADDR_W-1:2];
	wire access_w = i_psel & i_penable;
	wire setup_w = i_psel & ~i_penable;
	wire hit_pa_w = (idx_w == rpmc_pkg::IDX_PA_CFG);
	wire hit_modem_w = (idx_w == rpmc_pkg::IDX_MODEM_CFG);
	wire hit_rate_w = (idx_w == rpmc_pkg::IDX_RATE_CFG);
	wire hit_ctrl_w = (idx_w == rpmc_pkg::IDX_AMP_CTRL);
	wire hit_stat_w = (idx_w == rpmc_pkg::IDX_AMP_STAT);
	wire hit_fine_w = (idx_w == rpmc_pkg::IDX_FINE_PWR);
	wire hit_w = hit_pa_w | hit_modem_w | hit_rate_w | hit_ctrl_w | hit_stat_w | hit_fine_w;
	wire wr_w = access_w & i_pwrite & i_pstrb[0];
	wire wr_pa_w = wr_w & hit_pa_w;
	wire wr_fine_w = wr_w & hit_fine_w;
	wire [3:0] coarse_in_w = i_pwdata[rpmc_pkg::COARSE_LSB +: 4];
	// Coarse code becomes fine level four times code plus three
	wire [5:0] coarse_fine_w = {coarse_in_w, 2'b00} + rpmc_pkg::FINE_OFFSET;

	assign o_pready = 1'b1;
	assign o_pslverr = access_w & ~hit_w;
	assign o_prdata = prdata_r;

	// Ramp timing: step interval is bit period divided by codes per bit
	wire [2:0] ramp_code_w = pa_cfg_r[rpmc_pkg::RAMP_LSB +: 3];
	wire [3:0] ramp_shift_w = rpmc_pkg::RAMP_SHIFT_BASE - {1'b0, ramp_code_w};
	wire [11:0] step_raw_w = rate_r >> ramp_shift_w;
	wire [11:0] step_int_w = (step_raw_w == 12'h000) ? 12'h001 : step_raw_w;
	wire [5:0] target_w = amp_en_r ? fine_r : 6'h00;
	wire ramp_ok_w = (ramp_code_w != rpmc_pkg::RAMP_RESERVED);
	wire ramping_w = (level_r != target_w);
	// Reserved ramp code freezes the level rather than guessing a rate
	wire step_en_w = ramping_w & ramp_ok_w & (step_cnt_r >= step_int_w - 12'h001);

	assign level_nxt = !step_en_w ? level_r :
		(level_r < target_w) ? level_r + 6'h01 : level_r - 6'h01;

	// Read mux, captured in the setup phase so read data comes from flops
	wire [31:0] rd_w =
		hit_pa_w ? {24'h0, pa_cfg_r} :
		hit_modem_w ? {24'h0, modem_cfg_r} :
		hit_rate_w ? {20'h0, rate_r} :
		hit_ctrl_w ? {31'h0, amp_en_r} :
		hit_stat_w ? {24'h0, (level_r == target_w), ramping_w, level_r} :
		hit_fine_w ? {26'h0, fine_r} : 32'h0000_0000;

	// Modem field decode
	wire [1:0] if_filter_width_w = modem_cfg_r[rpmc_pkg::IF_FILTER_WIDTH_LSB +: 2];
	wire [2:0] mod_w = modem_cfg_r[rpmc_pkg::MOD_LSB +: 3];
	wire [2:0] demod_w = modem_cfg_r[rpmc_pkg::DEMOD_LSB +: 3];
	always_comb begin
		modem_nxt = '0;
		case (if_filter_width_w)
			2'h0: modem_nxt.if_bw_khz = rpmc_pkg::BW_KHZ_0;
			2'h1: modem_nxt.if_bw_khz = rpmc_pkg::BW_KHZ_1;
			2'h2: modem_nxt.if_bw_khz = rpmc_pkg::BW_KHZ_2;
			default: modem_nxt.if_bw_khz = rpmc_pkg::BW_KHZ_3;
		endcase
		// No separate IF setting: the widest filter carries its own IF
		modem_nxt.if_freq_300k = (if_filter_width_w == rpmc_pkg::IF_FILTER_WIDTH_300K);
		modem_nxt.mod_fsk = (mod_w == rpmc_pkg::MOD_FSK);
		modem_nxt.mod_gfsk = (mod_w == rpmc_pkg::MOD_GFSK);
		modem_nxt.mod_carrier = (mod_w == rpmc_pkg::MOD_CARRIER);
		modem_nxt.mod_reserved = ~(modem_nxt.mod_fsk | modem_nxt.mod_gfsk | modem_nxt.mod_carrier);
		modem_nxt.demod_common = (demod_w == rpmc_pkg::DEMOD_COMMON);
		modem_nxt.demod_reserved = ~modem_nxt.demod_common;
	end

	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			pa_cfg_r <= rpmc_pkg::PA_CFG_RST;
			fine_r <= rpmc_pkg::FINE_PWR_RST;
		end else if (wr_pa_w) begin
			pa_cfg_r <= i_pwdata[7:0];
			fine_r <= coarse_fine_w;
		end else if (wr_fine_w) begin
			fine_r <= i_pwdata[5:0];
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			modem_cfg_r <= rpmc_pkg::MODEM_CFG_RST;
			amp_en_r <= 1'b0;
		end else begin
			if (wr_w & hit_modem_w) modem_cfg_r <= i_pwdata[7:0];
			if (wr_w & hit_ctrl_w) amp_en_r <= i_pwdata[0];
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			rate_r <= rpmc_pkg::RATE_CFG_RST;
		end else if (access_w & i_pwrite & hit_rate_w) begin
			if (i_pstrb[0]) rate_r[7:0] <= i_pwdata[7:0];
			if (i_pstrb[1]) rate_r[11:8] <= i_pwdata[11:8];
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			level_r <= 6'h00;
			step_cnt_r <= 12'h000;
		end else begin
			level_r <= level_nxt;
			step_cnt_r <= (step_en_w | ~ramping_w) ? 12'h000 : step_cnt_r + 12'h001;
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			prdata_r <= 32'h0000_0000;
			amp_r <= '0;
			modem_r <= '0;
		end else begin
			if (setup_w & ~i_pwrite) prdata_r <= rd_w;
			amp_r.single_en <= ~pa_cfg_r[rpmc_pkg::STAGE_BIT];
			amp_r.diff_en <= pa_cfg_r[rpmc_pkg::STAGE_BIT];
			amp_r.level <= level_r;
			amp_r.ramping <= ramping_w;
			modem_r <= modem_nxt;
		end
	end

	assign o_amp = amp_r;
	assign o_modem = modem_r;

	// Helper for the ramp-interval check
	wire [8:0] cpb_w = 9'h100 >> (ramp_code_w - 3'h1);
	wire [20:0] prod_w = {9'h000, step_int_w} * {12'h000, cpb_w};
	wire [20:0] rate_ext_w = {9'h000, rate_r};

	// Outputs lag their source by one flop, so checks wait one cycle past reset
	AST_STAGE: assert property (@(posedge i_mclk) disable iff (i_srst)
		!$past(i_srst) |->
		(o_amp.diff_en == $past(pa_cfg_r[7]) && o_amp.single_en == ~o_amp.diff_en))
		else $error("amplifier stage enables do not follow stage select");
	AST_STAGE_EXCL: assert property (@(posedge i_mclk) disable iff (i_srst)
		!$past(i_srst) |-> o_amp.single_en != o_amp.diff_en)
		else $error("both or neither amplifier stage enabled");
	AST_COARSE_MAX: assert property (@(posedge i_mclk) disable iff (i_srst)
		wr_pa_w && coarse_in_w == 4'hF |=> fine_r == 6'h3F)
		else $error("coarse code 15 did not give fine level 63");
	AST_WR_PA: assert property (@(posedge i_mclk) disable iff (i_srst)
		wr_pa_w |=> pa_cfg_r == $past(i_pwdata[7:0]))
		else $error("amplifier config write lost");
	AST_PA_HOLD: assert property (@(posedge i_mclk) disable iff (i_srst)
		!wr_pa_w |=> $stable(pa_cfg_r))
		else $error("amplifier config changed without a write");
	AST_LEVEL_OUT: assert property (@(posedge i_mclk) disable iff (i_srst)
		!$past(i_srst) |-> o_amp.level == $past(level_r))
		else $error("output level does not follow ramp level");
	AST_PA_READ: assert property (@(posedge i_mclk) disable iff (i_srst)
		setup_w && !i_pwrite && hit_pa_w |=> o_prdata == {24'h0, $past(pa_cfg_r)})
		else $error("amplifier config read wrong");
	AST_RST_FINE: assert property (@(posedge i_mclk) disable iff (i_srst)
		$past(i_srst) |-> fine_r == {pa_cfg_r[6:3], 2'b11})
		else $error("reset fine level does not match reset coarse code");
	AST_FINE_WR: assert property (@(posedge i_mclk) disable iff (i_srst)
		wr_fine_w |=> fine_r == $past(i_pwdata[5:0]))
		else $error("fine level write lost");
	AST_FINE_KEEP: assert property (@(posedge i_mclk) disable iff (i_srst)
		!wr_pa_w && !wr_fine_w |=> $stable(fine_r))
		else $error("fine level changed without a write");
	AST_COARSE_MAP: assert property (@(posedge i_mclk) disable iff (i_srst)
		wr_pa_w |=> fine_r == {$past(i_pwdata[6:3]), 2'b11})
		else $error("fine level not four times coarse plus three");
	AST_RAMP_RATE: assert property (@(posedge i_mclk) disable iff (i_srst)
		ramp_ok_w && rate_ext_w >= {12'h000, cpb_w} |->
		prod_w <= rate_ext_w && prod_w + {12'h000, cpb_w} > rate_ext_w)
		else $error("step interval does not match codes per bit");
	AST_RAMP_STEP: assert property (@(posedge i_mclk) disable iff (i_srst)
		level_r != $past(level_r) |-> $past(step_en_w) &&
		(level_r == $past(level_r) + 6'h01 || level_r == $past(level_r) - 6'h01))
		else $error("power level moved without a single ramp step");
	AST_RAMP_FAST: assert property (@(posedge i_mclk) disable iff (i_srst)
		ramping_w && ramp_code_w == 3'h7 && rate_r == 12'h008 && $stable(target_w) |->
		##[1:2] level_r != $past(level_r))
		else $error("ramp did not step within the bit fraction");
	AST_RAMP_FREEZE: assert property (@(posedge i_mclk) disable iff (i_srst)
		ramp_code_w == 3'h0 |=> level_r == $past(level_r))
		else $error("level moved under reserved ramp code");
	AST_TARGET_HOLD: assert property (@(posedge i_mclk) disable iff (i_srst)
		!ramping_w |=> level_r == $past(level_r))
		else $error("level moved at target");
	AST_RAMP_UP: assert property (@(posedge i_mclk) disable iff (i_srst)
		step_en_w && level_r < target_w |=> level_r == $past(level_r) + 6'h01)
		else $error("upward ramp step wrong");
	AST_RAMP_DOWN: assert property (@(posedge i_mclk) disable iff (i_srst)
		step_en_w && level_r > target_w |=> level_r == $past(level_r) - 6'h01)
		else $error("downward ramp step wrong");
	AST_STEP_GAP: assert property (@(posedge i_mclk) disable iff (i_srst)
		step_en_w |=> !step_en_w || step_int_w == 12'h001)
		else $error("ramp steps closer than the step interval");
	AST_RAMP_FLAG: assert property (@(posedge i_mclk) disable iff (i_srst)
		!$past(i_srst) |-> o_amp.ramping == $past(ramping_w))
		else $error("ramping flag does not follow ramp state");
	AST_RATE_WR: assert property (@(posedge i_mclk) disable iff (i_srst)
		access_w && i_pwrite && hit_rate_w && i_pstrb == 4'hF |=>
		rate_r == $past(i_pwdata[11:0]))
		else $error("data rate write lost");
	AST_STAT_READ: assert property (@(posedge i_mclk) disable iff (i_srst)
		setup_w && !i_pwrite && hit_stat_w |=> o_prdata[5:0] == $past(level_r))
		else $error("status read does not give current level");

	// Decoded modem outputs, one flop behind the register
	AST_IF_FILTER_WIDTH: assert property (@(posedge i_mclk) disable iff (i_srst)
		!$past(i_srst) |-> ($past(if_filter_width_w) == 2'h1) == (o_modem.if_bw_khz == 9'h096))
		else $error("IF bandwidth decode wrong");
	AST_BW_100: assert property (@(posedge i_mclk) disable iff (i_srst)
		!$past(i_srst) |-> ($past(if_filter_width_w) == 2'h0) == (o_modem.if_bw_khz == 9'h064))
		else $error("IF bandwidth 100 kHz decode wrong");
	AST_BW_300: assert property (@(posedge i_mclk) disable iff (i_srst)
		!$past(i_srst) |-> ($past(if_filter_width_w) == 2'h3) == (o_modem.if_bw_khz == 9'h12C))
		else $error("IF bandwidth 300 kHz decode wrong");
	AST_WR_MODEM: assert property (@(posedge i_mclk) disable iff (i_srst)
		wr_w && hit_modem_w |=> modem_cfg_r == $past(i_pwdata[7:0]))
		else $error("modem config write lost");
	AST_MODEM_KEEP: assert property (@(posedge i_mclk) disable iff (i_srst)
		!(wr_w && hit_modem_w) |=> $stable(modem_cfg_r))
		else $error("modem config changed without a write");
	AST_MODEM_READ: assert property (@(posedge i_mclk) disable iff (i_srst)
		setup_w && !i_pwrite && hit_modem_w |=> o_prdata == {24'h0, $past(modem_cfg_r)})
		else $error("modem config read wrong");
	AST_IF300: assert property (@(posedge i_mclk) disable iff (i_srst)
		o_modem.if_freq_300k == (o_modem.if_bw_khz == 9'h12C))
		else $error("IF shift and 300 kHz width disagree");
	AST_MOD: assert property (@(posedge i_mclk) disable iff (i_srst)
		!$past(i_srst) |-> $onehot({o_modem.mod_fsk, o_modem.mod_gfsk, o_modem.mod_carrier,
		o_modem.mod_reserved}) && (o_modem.mod_carrier == ($past(mod_w) == 3'h3)))
		else $error("modulation decode wrong");
	AST_MOD_FSK: assert property (@(posedge i_mclk) disable iff (i_srst)
		!$past(i_srst) |-> o_modem.mod_fsk == ($past(mod_w) == 3'h0))
		else $error("two-level modulation decode wrong");
	AST_MOD_GFSK: assert property (@(posedge i_mclk) disable iff (i_srst)
		!$past(i_srst) |-> o_modem.mod_gfsk == ($past(mod_w) == 3'h1))
		else $error("Gaussian modulation decode wrong");
	AST_DEMOD: assert property (@(posedge i_mclk) disable iff (i_srst)
		!$past(i_srst) |-> o_modem.demod_common == ($past(demod_w) == 3'h0))
		else $error("demodulation decode wrong");
	AST_DEMOD_RES: assert property (@(posedge i_mclk) disable iff (i_srst)
		!$past(i_srst) |-> o_modem.demod_reserved == ($past(demod_w) != 3'h0))
		else $error("reserved demodulation code not flagged");

	COV_RAMP_DONE: cover property (@(posedge i_mclk) disable iff (i_srst)
		amp_en_r && ramping_w ##1 !ramping_w);
	COV_RAMP_DOWN: cover property (@(posedge i_mclk) disable iff (i_srst)
		!amp_en_r && ramping_w ##1 !ramping_w);
	COV_FINE_WRITE: cover property (@(posedge i_mclk) disable iff (i_srst) wr_fine_w);
	COV_CARRIER: cover property (@(posedge i_mclk) disable iff (i_srst) o_modem.mod_carrier);
	COV_IF300: cover property (@(posedge i_mclk) disable iff (i_srst) o_modem.if_freq_300k);
endmodule // rpmc_top

/* bench/rpmc_top_tb.sv */
// Self-checking bench for the amplifier and modem configuration registers
`timescale 1ns/1ps
module rpmc_top_tb;
	logic i_mclk = 1'b0;
	logic i_srst = 1'b1;
	logic psel = 1'b0;
	logic pen = 1'b0;
	logic pwr = 1'b0;
	logic [11:0] padr = 12'h000;
	logic [31:0] pwd = 32'h00000000;
	logic [31:0] prd;
	logic prdy;
	logic perr;
	rpmc_pkg::rpmc_amp_t amp;
	rpmc_pkg::rpmc_modem_t mdm;
	logic [31:0] rd;
	logic err;
	logic [8:0] bw_tab [4] = '{9'h064, 9'h096, 9'h0C8, 9'h12C};
	int n_fail = 0;
	int n_checks = 0;
	always #20 i_mclk = ~i_mclk;
	rpmc_top i_rpmc_top (.i_mclk(i_mclk), .i_srst(i_srst), .i_psel(psel), .i_penable(pen),
		.i_pwrite(pwr), .i_paddr(padr), .i_pwdata(pwd), .i_pstrb(4'hF), .o_prdata(prd),
		.o_pready(prdy), .o_pslverr(perr), .o_amp(amp), .o_modem(mdm));
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Register index times four is the byte address, since the registers sit on word boundaries
	task apb(input logic wr, input logic [9:0] idx, input logic [31:0] wd);
		int n;
		@(posedge i_mclk);
		psel <= 1'b1;
		pen <= 1'b0;
		pwr <= wr;
		padr <= {idx, 2'b00};
		pwd <= wd;
		@(posedge i_mclk);
		pen <= 1'b1;
		n = 0;
		do begin
			@(posedge i_mclk);
			n++;
		end while (prdy !== 1'b1 && n < 16);
		rd = prd;
		err = perr;
		if (prdy !== 1'b1) n_fail++;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask
	task t_reset;
		apb(1'b0, rpmc_pkg::IDX_PA_CFG, 32'h0);
		chk(rd, 32'h07);
		apb(1'b0, rpmc_pkg::IDX_FINE_PWR, 32'h0);
		chk(rd, 32'h03);
		apb(1'b0, 10'h000, 32'h0);
		chk({31'h0, err}, 32'h1);
		chk(rd, 32'h0);
	endtask
	task t_pa;
		for (int c = 0; c < 16; c += 15) begin
			apb(1'b1, rpmc_pkg::IDX_PA_CFG, {24'h0, c[0], c[3:0], 3'h1});
			apb(1'b0, rpmc_pkg::IDX_FINE_PWR, 32'h0);
			chk(rd, 4 * c + 3);
			repeat (2) @(posedge i_mclk);
			chk({31'h0, amp.single_en}, {31'h0, ~c[0]});
			chk({31'h0, amp.diff_en}, {31'h0, c[0]});
		end
		apb(1'b1, rpmc_pkg::IDX_FINE_PWR, 32'h2A);
		apb(1'b0, rpmc_pkg::IDX_FINE_PWR, 32'h0);
		chk(rd, 32'h2A);
	endtask
	task t_modem;
		rpmc_pkg::rpmc_modem_t e;
		logic [7:0] wd;
		for (int i = 0; i < 8; i++) begin
			wd = {i[1:0], i[2:0], (i == 7) ? 3'h1 : 3'h0};
			e.if_bw_khz = bw_tab[i[1:0]];
			e.if_freq_300k = (i[1:0] == 2'h3);
			e.mod_fsk = (i == 0);
			e.mod_gfsk = (i == 1);
			e.mod_carrier = (i == 3);
			e.mod_reserved = (i == 2) || (i > 3);
			e.demod_common = (i != 7);
			e.demod_reserved = (i == 7);
			apb(1'b1, rpmc_pkg::IDX_MODEM_CFG, {24'h0, wd});
			apb(1'b0, rpmc_pkg::IDX_MODEM_CFG, 32'h0);
			chk(rd, {24'h0, wd});
			repeat (2) @(posedge i_mclk);
			chk({17'h0, mdm}, {17'h0, e});
		end
	endtask
	// Span in cycles tells one ramp code from another at a bit period of 64 cycles
	task t_ramp(input logic [7:0] cfg, input logic en, input logic [5:0] tgt,
		input int lo, input int hi);
		int n;
		apb(1'b1, rpmc_pkg::IDX_PA_CFG, {24'h0, cfg});
		apb(1'b1, rpmc_pkg::IDX_AMP_CTRL, {31'h0, en});
		n = 0;
		while (amp.level !== tgt && n < 400) begin
			@(posedge i_mclk);
			n++;
		end
		chk({31'h0, (n >= lo && n <= hi)}, 32'h1);
		apb(1'b0, rpmc_pkg::IDX_AMP_STAT, 32'h0);
		chk({26'h0, rd[5:0]}, {26'h0, tgt});
	endtask
	task test_done;
		$display("Checks %0d, errors %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	initial begin
		repeat (8) @(posedge i_mclk);
		i_srst <= 1'b0;
		t_reset;
		t_pa;
		t_modem;
		apb(1'b1, rpmc_pkg::IDX_RATE_CFG, 32'h40);
		t_ramp(8'h0D, 1'b1, 6'h07, 24, 34);
		t_ramp(8'h0F, 1'b0, 6'h00, 108, 118);
		apb(1'b1, rpmc_pkg::IDX_RATE_CFG, 32'h8);
		t_ramp(8'h0F, 1'b1, 6'h07, 12, 18);
		test_done;
	end
	// Whole run needs about three hundred cycles
	initial begin
		repeat (5000) @(posedge i_mclk);
		n_fail++;
		test_done;
	end
endmodule // rpmc_top_tb
